//--- hw/rsec_params.svh
// Constants of the RS(118,102) encoder and erasure decoder.
// Assumes 8-bit symbols; included by the design file only.
`ifndef RSEC_PARAMS_SVH
`define RSEC_PARAMS_SVH
`define RSEC_K          7'd102
`define RSEC_N          7'd118
`define RSEC_R          5'd16
`define RSEC_FIELD_POLY 9'h11d
`define RSEC_POLY_LO    8'h1d
`define RSEC_ALPHA      8'h02
`define RSEC_FCR        0
`define RSEC_TMAX       8
`define RSEC_ERS_SAT    5'd17
`define RSEC_FIFO_DEPTH 8
`define RSEC_FIFO_WIDTH 9
`endif

//--- hw/rsec_pkg.sv
// Types shared by the codec design.
// Assumes the constants header is on the include path.
package rsec_pkg;
    typedef logic [7:0]       rsec_sym_t;
    typedef logic [16:0][7:0] rsec_poly_t;
    typedef logic [15:0][7:0] rsec_syn_t;
    typedef enum logic [2:0] {
        ST_LOAD, ST_KEY, ST_OMEGA, ST_CHIEN, ST_OUT
    } rsec_state_t;
endpackage

//--- hw/rsec_codec.sv
// RS(118,102) systematic encoder and error-and-erasure decoder with FIFO.
// Assumes one clock, streaming upstream and downstream logic on core_clk.
// Functional notes
// - Encoder turns 102 data symbols into 118 by adding 16 parity.
// - Every codeword is a multiple of the generator polynomial.
// - Generator roots are alpha^0 up to alpha^15.
// - Syndrome j sums each received symbol times its location to power j.
// - Decoder corrects t errors and s erasures when 2t+s <= 16.
// - A count of corrected symbols, 0 to 16, goes with each word; it reads 17 when more than 16 erasures arrive.
// - Failure is flagged when 2t+s exceeds the 16 parity symbols.
// - Within capability the delivered data equals the original message.
// - Erasure locations are known; their magnitudes may be zero.
// - Key stage finds least-degree locator and evaluator mod x^16.
// - Locator roots give positions; a closed form gives the values.
// - Received word waits in a buffer; correction is by XOR.
// - Symbols are elements of a characteristic-2 extension field.
// - Field arithmetic uses polynomial 11D hex, 8-bit symbols.
// - Generator has degree 16 over sixteen powers of 02 hex from zero.
// - Without erasures every pattern of up to 8 errors is corrected.
`timescale 1ns/10ps
`include "rsec_params.svh"

module rsec_fifo #(
    parameter int W = `RSEC_FIFO_WIDTH,
    parameter int D = `RSEC_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Filling side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage needs no reset; only entries below the count are visible.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap explicitly so the depth need not be a power of two.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module rsec_codec #(
    parameter int FIFO_DEPTH = `RSEC_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Encoder data in.
    input  wire logic              enc_in_valid,
    output logic                   enc_in_ready,
    input  wire rsec_pkg::rsec_sym_t enc_in_data,
    // Encoder codeword out.
    output logic                   enc_out_valid,
    input  wire logic              enc_out_ready,
    output rsec_pkg::rsec_sym_t    enc_out_data,
    output logic                   enc_out_last,
    // Decoder received word in.
    input  wire logic              dec_in_valid,
    output logic                   dec_in_ready,
    input  wire rsec_pkg::rsec_sym_t dec_in_data,
    input  wire logic              dec_in_erase,
    // Decoder data out.
    output logic                   dec_out_valid,
    input  wire logic              dec_out_ready,
    output rsec_pkg::rsec_sym_t    dec_out_data,
    output logic                   dec_out_last,
    // Decoder status.
    output logic                   dec_stat_valid,
    output logic [4:0]             dec_corr_count,
    output logic                   dec_fail
);
    // field product
    // Shift-and-add product reduced by the field polynomial.
    function automatic rsec_pkg::rsec_sym_t gf_mul(
        input rsec_pkg::rsec_sym_t a, input rsec_pkg::rsec_sym_t b);
        rsec_pkg::rsec_sym_t p;
        rsec_pkg::rsec_sym_t x;
        p = '0;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = x[7] ? ({x[6:0], 1'b0} ^ `RSEC_POLY_LO) : {x[6:0], 1'b0};
        end
        return p;
    endfunction

    function automatic rsec_pkg::rsec_sym_t gf_pow(input int n);
        rsec_pkg::rsec_sym_t r;
        r = 8'h01;
        for (int i = 0; i < n; i++) r = gf_mul(r, `RSEC_ALPHA);
        return r;
    endfunction

    // Inverse as a^254; seven squarings keep the logic shallow enough.
    function automatic rsec_pkg::rsec_sym_t gf_inv(
        input rsec_pkg::rsec_sym_t a);
        rsec_pkg::rsec_sym_t sq;
        rsec_pkg::rsec_sym_t r;
        sq = a;
        r  = 8'h01;
        for (int i = 1; i < 8; i++) begin
            sq = gf_mul(sq, sq);
            r  = gf_mul(r, sq);
        end
        return r;
    endfunction

    // generator product
    // Product of (x + alpha^i) for sixteen roots from the zeroth power.
    function automatic rsec_pkg::rsec_poly_t gen_poly();
        rsec_pkg::rsec_poly_t g;
        rsec_pkg::rsec_sym_t  rt;
        g = '0;
        g[0] = 8'h01;
        for (int i = 0; i < 16; i++) begin
            rt = gf_pow(i + `RSEC_FCR);
            for (int j = 16; j > 0; j--) g[j] = g[j-1] ^ gf_mul(g[j], rt);
            g[0] = gf_mul(g[0], rt);
        end
        return g;
    endfunction

    function automatic rsec_pkg::rsec_poly_t inv_pows();
        rsec_pkg::rsec_poly_t p;
        for (int j = 0; j < 17; j++) p[j] = gf_pow((255 - j) % 255);
        return p;
    endfunction

    localparam rsec_pkg::rsec_poly_t GEN      = gen_poly();
    localparam rsec_pkg::rsec_poly_t AINVP    = inv_pows();
    localparam rsec_pkg::rsec_sym_t  LOC_TOP  = gf_pow(117);
    localparam rsec_pkg::rsec_sym_t  ALPHA_IV = gf_pow(254);

    // Encoder state.
    logic [6:0]          enc_cnt_q;
    rsec_pkg::rsec_syn_t par_q;
    logic                enc_adv;
    logic                enc_take;
    logic                enc_par;
    rsec_pkg::rsec_sym_t enc_fb;

    // The output slot advances when empty or being taken downstream.
    assign enc_adv      = !enc_out_valid || enc_out_ready;
    assign enc_in_ready = (enc_cnt_q < `RSEC_K) && enc_adv;
    assign enc_take     = enc_in_valid && enc_in_ready;
    assign enc_par      = (enc_cnt_q >= `RSEC_K) && enc_adv;
    assign enc_fb       = enc_in_data ^ par_q[15];

    // division remainder
    // Remainder register of data times x^16 divided by the generator.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            par_q <= '0;
        end else if (enc_take) begin
            for (int i = 0; i < 16; i++) begin
                par_q[i] <= (i > 0 ? par_q[i-1] : 8'h00)
                            ^ gf_mul(GEN[i], enc_fb);
            end
        end else if (enc_par) begin
            par_q <= {par_q[14:0], 8'h00};
        end
    end

    // Symbol counter across data and parity phases.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enc_cnt_q <= '0;
        end else if (enc_take || enc_par) begin
            enc_cnt_q <= (enc_cnt_q == `RSEC_N - 7'd1) ? '0 : enc_cnt_q + 7'd1;
        end
    end

    // systematic output
    // Data goes out untouched, then parity highest coefficient first.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enc_out_valid <= 1'b0;
            enc_out_data  <= '0;
            enc_out_last  <= 1'b0;
        end else if (enc_take) begin
            enc_out_valid <= 1'b1;
            enc_out_data  <= enc_in_data;
            enc_out_last  <= 1'b0;
        end else if (enc_par) begin
            enc_out_valid <= 1'b1;
            enc_out_data  <= par_q[15];
            enc_out_last  <= enc_cnt_q == `RSEC_N - 7'd1;
        end else if (enc_out_ready) begin
            enc_out_valid <= 1'b0;
        end
    end

    // Decoder state.
    rsec_pkg::rsec_state_t st_q;
    rsec_pkg::rsec_sym_t   buf_q [`RSEC_N];
    rsec_pkg::rsec_syn_t   syn_q;
    rsec_pkg::rsec_syn_t   omg_q;
    rsec_pkg::rsec_poly_t  lam_q;
    rsec_pkg::rsec_poly_t  bb_q;
    rsec_pkg::rsec_poly_t  tl_q;
    rsec_pkg::rsec_syn_t   to_q;
    rsec_pkg::rsec_sym_t   loc_q;
    logic [6:0]            idx_q;
    logic [4:0]            len_q;
    logic [4:0]            r_q;
    logic [4:0]            ers_q;
    logic [6:0]            roots_q;
    logic                  bad_q;
    logic                  dec_take;
    logic                  ers_take;
    logic                  restart;
    logic                  fifo_in_ready;
    // Combinational results.
    rsec_pkg::rsec_poly_t  gam_nx;
    rsec_pkg::rsec_syn_t   omg_nx;
    rsec_pkg::rsec_sym_t   delta;
    rsec_pkg::rsec_sym_t   ev_sum;
    rsec_pkg::rsec_sym_t   od_sum;
    rsec_pkg::rsec_sym_t   om_sum;
    rsec_pkg::rsec_sym_t   err_val;
    logic                  is_root;

    assign dec_in_ready = st_q == rsec_pkg::ST_LOAD;
    assign dec_take     = dec_in_valid && dec_in_ready;
    assign ers_take     = dec_take && dec_in_erase && ers_q != `RSEC_ERS_SAT;
    assign restart      = st_q == rsec_pkg::ST_OUT && fifo_in_ready
                          && idx_q == `RSEC_K - 7'd1;

    // Erasure locator update, discrepancy, evaluator and search sums.
    always_comb begin
        gam_nx = lam_q;
        delta  = '0;
        omg_nx = '0;
        ev_sum = '0;
        od_sum = '0;
        om_sum = '0;
        for (int j = 1; j < 17; j++)
            gam_nx[j] = lam_q[j] ^ gf_mul(loc_q, lam_q[j-1]);
        for (int j = 0; j < 16; j++) begin
            if (5'(j) <= r_q)
                delta = delta ^ gf_mul(lam_q[j], syn_q[r_q - 5'(j)]);
            for (int i = 0; i <= j; i++)
                omg_nx[j] = omg_nx[j] ^ gf_mul(syn_q[i], lam_q[j-i]);
            om_sum = om_sum ^ to_q[j];
        end
        for (int j = 0; j < 17; j++) begin
            if (j % 2 == 0) ev_sum = ev_sum ^ tl_q[j];
            else od_sum = od_sum ^ tl_q[j];
        end
    end

    // root test and closed-form value
    // With the first root at zero the value is omega over the odd part.
    assign is_root = ev_sum == od_sum;
    assign err_val = gf_mul(om_sum, gf_inv(od_sum));

    // Sequencer over load, key solve, evaluator, search and output.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q  <= rsec_pkg::ST_LOAD;
            idx_q <= '0;
        end else begin
            case (st_q)
                rsec_pkg::ST_LOAD: if (dec_take) begin
                    idx_q <= (idx_q == `RSEC_N - 7'd1) ? '0 : idx_q + 7'd1;
                    if (idx_q == `RSEC_N - 7'd1) st_q <= rsec_pkg::ST_KEY;
                end
                rsec_pkg::ST_KEY: if (r_q >= 5'd15) st_q <= rsec_pkg::ST_OMEGA;
                rsec_pkg::ST_OMEGA: st_q <= rsec_pkg::ST_CHIEN;
                rsec_pkg::ST_CHIEN: begin
                    idx_q <= (idx_q == `RSEC_N - 7'd1) ? '0 : idx_q + 7'd1;
                    if (idx_q == `RSEC_N - 7'd1) st_q <= rsec_pkg::ST_OUT;
                end
                rsec_pkg::ST_OUT: if (fifo_in_ready) begin
                    idx_q <= restart ? '0 : idx_q + 7'd1;
                    if (restart) st_q <= rsec_pkg::ST_LOAD;
                end
                default: st_q <= rsec_pkg::ST_LOAD;
            endcase
        end
    end

    // Horner syndromes
    // Symbols arrive highest location first, so each step scales by alpha^j.
    for (genvar j = 0; j < 16; j++) begin : g_syn
        always_ff @(posedge core_clk) begin
            if (!rst_n || restart) begin
                syn_q[j] <= '0;
            end else if (dec_take) begin
                syn_q[j] <= gf_mul(syn_q[j], gf_pow(j + `RSEC_FCR)) ^ dec_in_data;
            end
        end
    end

    // erasure-seeded key solver
    // Locator starts as the erasure product; sixteen minus s steps remain.
    always_ff @(posedge core_clk) begin
        if (!rst_n || restart) begin
            lam_q <= 136'h01;
            bb_q  <= 136'h01;
            len_q <= '0;
            r_q   <= '0;
            ers_q <= '0;
            loc_q <= LOC_TOP;
        end else if (st_q == rsec_pkg::ST_LOAD) begin
            if (dec_take) loc_q <= gf_mul(loc_q, ALPHA_IV);
            if (ers_take) begin
                lam_q <= gam_nx;
                bb_q  <= gam_nx;
                ers_q <= ers_q + 5'd1;
                len_q <= ers_q + 5'd1;
                r_q   <= ers_q + 5'd1;
            end
        end else if (st_q == rsec_pkg::ST_KEY && r_q < `RSEC_R) begin
            r_q <= r_q + 5'd1;
            if (delta == '0) begin
                bb_q <= {bb_q[15:0], 8'h00};
            end else begin
                for (int j = 0; j < 17; j++)
                    lam_q[j] <= lam_q[j]
                        ^ gf_mul(delta, j > 0 ? bb_q[j-1] : 8'h00);
                if ({1'b0, len_q, 1'b0} <= {2'b00, r_q} + {2'b00, ers_q}) begin
                    for (int j = 0; j < 17; j++)
                        bb_q[j] <= gf_mul(gf_inv(delta), lam_q[j]);
                    len_q <= r_q + 5'd1 + ers_q - len_q;
                end else begin
                    bb_q <= {bb_q[15:0], 8'h00};
                end
            end
        end
    end

    // Search terms step from alpha^0 toward alpha^-117 each cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tl_q    <= '0;
            to_q    <= '0;
            omg_q   <= '0;
            roots_q <= '0;
            bad_q   <= 1'b0;
        end else if (st_q == rsec_pkg::ST_OMEGA) begin
            tl_q    <= lam_q;
            to_q    <= omg_nx;
            omg_q   <= omg_nx;
            roots_q <= '0;
            bad_q   <= 1'b0;
        end else if (st_q == rsec_pkg::ST_CHIEN) begin
            for (int j = 0; j < 17; j++) tl_q[j] <= gf_mul(tl_q[j], AINVP[j]);
            for (int j = 0; j < 16; j++) to_q[j] <= gf_mul(to_q[j], AINVP[j]);
            if (is_root) roots_q <= roots_q + 7'd1;
            if (is_root && od_sum == '0) bad_q <= 1'b1;
        end
    end

    // buffered word corrected by XOR
    // Location alpha^k sits at buffer index 117-k.
    always_ff @(posedge core_clk) begin
        if (dec_take) begin
            buf_q[idx_q] <= dec_in_data;
        end else if (st_q == rsec_pkg::ST_CHIEN && is_root) begin
            buf_q[`RSEC_N - 7'd1 - idx_q] <=
                buf_q[`RSEC_N - 7'd1 - idx_q] ^ err_val;
        end
    end

    // capability check and count
    // Fails on too many erasures, 2L-s over 16, or roots not matching L.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dec_stat_valid <= 1'b0;
            dec_corr_count <= '0;
            dec_fail       <= 1'b0;
        end else begin
            dec_stat_valid <= 1'b0;
            if (st_q == rsec_pkg::ST_CHIEN && idx_q == `RSEC_N - 7'd1) begin
                dec_stat_valid <= 1'b1;
                dec_fail <= ers_q > `RSEC_R || bad_q || (is_root && od_sum == '0)
                    || {1'b0, len_q, 1'b0} > 7'(`RSEC_R) + {2'b00, ers_q}
                    || roots_q + 7'(is_root) != {2'b00, len_q};
                dec_corr_count <= len_q;
            end
        end
    end

    // Data symbols pass an 8-deep FIFO; a stalled reader holds the decoder.
    rsec_fifo #(
        .W (`RSEC_FIFO_WIDTH),
        .D (FIFO_DEPTH)
    ) u_out_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (st_q == rsec_pkg::ST_OUT),
        .in_ready  (fifo_in_ready),
        .in_data   ({idx_q == `RSEC_K - 7'd1, buf_q[idx_q]}),
        .out_valid (dec_out_valid),
        .out_ready (dec_out_ready),
        .out_data  ({dec_out_last, dec_out_data})
    );

    // Checks on encoder and decoder timing and status.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    enc_stall_a: assert property (enc_cnt_q >= `RSEC_K |-> !enc_in_ready)
        else $error("encoder accepted data in parity phase");
    enc_pass_a: assert property (enc_take |=> enc_out_valid && !enc_out_last
        && enc_out_data == $past(enc_in_data)) else $error("data not passed");
    enc_flush_a: assert property (enc_par && enc_cnt_q == `RSEC_N - 7'd1
        |=> par_q == '0 && enc_out_last) else $error("remainder left over");
    dec_hold_a: assert property (st_q != rsec_pkg::ST_LOAD |-> !dec_in_ready)
        else $error("decoder took input while busy");
    key_bound_a: assert property ($rose(st_q == rsec_pkg::ST_KEY)
        |-> ##[1:17] st_q == rsec_pkg::ST_OMEGA) else $error("key stage overran");
    search_len_a: assert property ($rose(st_q == rsec_pkg::ST_CHIEN)
        |-> ##117 st_q == rsec_pkg::ST_CHIEN ##1 dec_stat_valid)
        else $error("search length wrong");
    ers_fail_a: assert property (st_q == rsec_pkg::ST_KEY && ers_q > `RSEC_R
        |-> ##[1:120] dec_stat_valid && dec_fail) else $error("no failure flag");
    count_rng_a: assert property (dec_stat_valid && !dec_fail
        |-> dec_corr_count <= `RSEC_R) else $error("count out of range");

    cover property (dec_stat_valid && dec_fail);
    cover property (dec_stat_valid && !dec_fail && dec_corr_count != '0);
    cover property (st_q == rsec_pkg::ST_OUT && !fifo_in_ready);
    cover property (enc_out_valid && enc_out_last && enc_out_ready);
endmodule

//--- tb/rsec_sink.sv
// Downstream sink model for both outputs of the codec, with random stalls.
// Assumes that the codec outputs change only just after rising edges.
`timescale 1ns/10ps
module rsec_sink (
    // Clock and stall control.
    input  wire logic                core_clk,
    input  wire logic                hold_off,
    // Encoder codeword side.
    input  wire logic                enc_out_valid,
    input  wire rsec_pkg::rsec_sym_t enc_out_data,
    input  wire logic                enc_out_last,
    output logic                     enc_out_ready,
    // Decoder data side.
    input  wire logic                dec_out_valid,
    input  wire rsec_pkg::rsec_sym_t dec_out_data,
    input  wire logic                dec_out_last,
    output logic                     dec_out_ready
);
    logic [8:0] enc_q [$];
    logic [8:0] dec_q [$];

    // Readies move at the falling edge; a quarter of cycles stall.
    initial begin
        enc_out_ready = 1'b0;
        dec_out_ready = 1'b0;
        forever begin
            @(negedge core_clk);
            enc_out_ready = !hold_off && ($urandom % 4 != 0);
            dec_out_ready = !hold_off && ($urandom % 4 != 0);
        end
    end

    // Keep every symbol taken, with its last flag on top.
    always @(posedge core_clk) begin
        if (enc_out_valid === 1'b1 && enc_out_ready)
            enc_q.push_back({enc_out_last, enc_out_data});
        if (dec_out_valid === 1'b1 && dec_out_ready)
            dec_q.push_back({dec_out_last, dec_out_data});
    end
endmodule

//--- tb/rsec_codec_bench.sv
// Self-checking bench for the RS(118,102) encoder and decoder.
// Assumes the sink model drives both downstream readies.
`timescale 1ns/10ps
module rsec_codec_bench;
    logic                core_clk;
    logic                rst_n;
    logic                enc_in_valid;
    logic                enc_in_ready;
    rsec_pkg::rsec_sym_t enc_in_data;
    logic                enc_out_valid;
    logic                enc_out_ready;
    rsec_pkg::rsec_sym_t enc_out_data;
    logic                enc_out_last;
    logic                dec_in_valid;
    logic                dec_in_ready;
    rsec_pkg::rsec_sym_t dec_in_data;
    logic                dec_in_erase;
    logic                dec_out_valid;
    logic                dec_out_ready;
    rsec_pkg::rsec_sym_t dec_out_data;
    logic                dec_out_last;
    logic                dec_stat_valid;
    logic [4:0]          dec_corr_count;
    logic                dec_fail;
    logic                hold_off;
    logic [4:0]          st_cnt;
    logic                st_fail;
    int                  st_seen = 0;
    int                  n_fail;
    int                  check_count;
    logic [7:0]          g [0:16];
    logic [7:0]          msg [0:101];
    logic [7:0]          cw [0:117];
    logic [8:0]          enc_exp [$];
    int                  ne [7] = '{0, 8, 8, 0, 4, 1, 0};
    int                  ns [7] = '{0, 0, 0, 16, 8, 14, 17};

    rsec_codec #(.FIFO_DEPTH(8)) rsec_codec_inst (.core_clk, .rst_n,
        .enc_in_valid, .enc_in_ready, .enc_in_data, .enc_out_valid,
        .enc_out_ready, .enc_out_data, .enc_out_last, .dec_in_valid,
        .dec_in_ready, .dec_in_data, .dec_in_erase, .dec_out_valid,
        .dec_out_ready, .dec_out_data, .dec_out_last, .dec_stat_valid,
        .dec_corr_count, .dec_fail);

    rsec_sink rsec_sink_inst (.core_clk, .hold_off, .enc_out_valid,
        .enc_out_data, .enc_out_last, .enc_out_ready, .dec_out_valid,
        .dec_out_data, .dec_out_last, .dec_out_ready);

    // Free-running clock, 10 ns period.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Latch the status of each searched word at its pulse.
    always @(posedge core_clk) begin
        if (dec_stat_valid === 1'b1) begin
            st_cnt  <= dec_corr_count;
            st_fail <= dec_fail;
            st_seen <= st_seen + 1;
        end
    end

    task automatic complete_run();
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [8:0] seen,
                         input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Field product reduced by 11d hex, bit by bit.
    function automatic logic [7:0] gf_mul(logic [7:0] a, logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i])
                p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1d : 8'h00);
        end
        return p;
    endfunction

    task automatic build_gen();
        logic [7:0] r;
        r = 8'h01;
        for (int k = 0; k <= 16; k++)
            g[k] = (k == 0) ? 8'h01 : 8'h00;
        for (int i = 0; i < 16; i++) begin
            for (int k = 16; k > 0; k--)
                g[k] = g[k-1] ^ gf_mul(g[k], r);
            g[0] = gf_mul(g[0], r);
            r = gf_mul(r, 8'h02);
        end
    endtask

    task automatic ref_encode();
        logic [7:0] p [0:15];
        logic [7:0] fb;
        for (int j = 0; j < 16; j++)
            p[j] = 8'h00;
        for (int i = 0; i < 102; i++) begin
            cw[i] = msg[i];
            fb = msg[i] ^ p[15];
            for (int j = 15; j > 0; j--)
                p[j] = p[j-1] ^ gf_mul(fb, g[j]);
            p[0] = gf_mul(fb, g[0]);
        end
        for (int j = 0; j < 16; j++)
            cw[102+j] = p[15-j];
    endtask

    // Offer one symbol at the falling edge and hold it until it is taken.
    task automatic send(input logic enc, input logic [7:0] d, input logic e);
        int n;
        @(negedge core_clk);
        enc_in_valid = enc;
        dec_in_valid = !enc;
        enc_in_data = d;
        dec_in_data = d;
        dec_in_erase = e;
        for (n = 0; n < 5000; n++) begin
            #4;
            if ((enc ? enc_in_ready : dec_in_ready) === 1'b1)
                break;
            @(negedge core_clk);
        end
        if (n == 5000) begin
            n_fail++;
            complete_run();
        end
        @(posedge core_clk);
    endtask

    task automatic wait_for(input logic dec, input int want);
        int n;
        for (n = 0; n < 20000; n++) begin
            if ((dec ? rsec_sink_inst.dec_q.size()
                     : rsec_sink_inst.enc_q.size()) >= want)
                break;
            @(posedge core_clk);
        end
        if (n == 20000) begin
            n_fail++;
            complete_run();
        end
    endtask

    // One received word with ners erasures first, then nerr errors.
    task automatic dec_case(input int nerr, input int ners, input int k);
        int p [0:117];
        int t;
        int s0;
        logic [7:0] m;
        logic [7:0] rx [0:117];
        logic er [0:117];
        for (int j = 0; j < 102; j++)
            msg[j] = $urandom;
        ref_encode();
        for (int j = 0; j < 118; j++) begin
            p[j] = (k == 1) ? ((j % 2) ? 117 - j / 2 : j / 2) : j;
            rx[j] = cw[j];
            er[j] = 1'b0;
        end
        for (int j = 117; j > 0 && k != 1; j--) begin
            t = $urandom % (j + 1);
            {p[j], p[t]} = {p[t], p[j]};
        end
        for (int j = 0; j < ners + nerr; j++) begin
            m = (j < ners && j % 3 == 0) ? 8'h00 : 8'($urandom % 255 + 1);
            rx[p[j]] = cw[p[j]] ^ m;
            er[p[j]] = (j < ners);
        end
        s0 = st_seen;
        rsec_sink_inst.dec_q.delete();
        hold_off = (k == 2);
        for (int j = 0; j < 118; j++)
            send(1'b0, rx[j], er[j]);
        @(negedge core_clk);
        dec_in_valid = 1'b0;
        if (k == 2) begin
            repeat (300) @(posedge core_clk);
            @(negedge core_clk);
            check("busy", {8'h00, dec_in_ready}, 9'h000);
            check("held", {8'h00, dec_out_valid}, 9'h001);
            hold_off = 1'b0;
        end
        wait_for(1'b1, 102);
        repeat (2) @(negedge core_clk);
        check("empty", {8'h00, dec_out_valid}, 9'h000);
        check("words", 9'(st_seen - s0), 9'h001);
        check("count", {4'h0, st_cnt},
              ners > 16 ? 9'h011 : 9'(ners + nerr));
        check("fail", {8'h00, st_fail}, {8'h00, ners > 16});
        for (int j = 0; j < 102 && ners <= 16; j++)
            check("data", rsec_sink_inst.dec_q[j], {j == 101, msg[j]});
    endtask

    // Main sequence: reset, two back-to-back codewords, then decodes.
    initial begin
        void'($urandom(32'hd372));
        rst_n = 1'b0;
        enc_in_valid = 1'b0;
        enc_in_data = 8'h00;
        dec_in_valid = 1'b0;
        dec_in_data = 8'h00;
        dec_in_erase = 1'b0;
        hold_off = 1'b0;
        n_fail = 0;
        check_count = 0;
        build_gen();
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        for (int w = 0; w < 2; w++) begin
            for (int j = 0; j < 102; j++)
                msg[j] = (w == 0) ? 8'hff : 8'($urandom);
            ref_encode();
            for (int j = 0; j < 118; j++)
                enc_exp.push_back({j == 117, cw[j]});
            for (int j = 0; j < 102; j++)
                send(1'b1, msg[j], 1'b0);
        end
        @(negedge core_clk);
        enc_in_valid = 1'b0;
        wait_for(1'b0, 236);
        for (int j = 0; j < 236; j++)
            check("code", rsec_sink_inst.enc_q[j], enc_exp[j]);
        for (int k = 0; k < 7; k++)
            dec_case(ne[k], ns[k], k);
        for (int k = 0; k < 6; k++) begin
            t_rand_case();
        end
        complete_run();
    end

    // Random mixes of errors and erasures within capability.
    task automatic t_rand_case();
        int nerr;
        nerr = $urandom % 9;
        dec_case(nerr, $urandom % (17 - 2 * nerr), 9);
    endtask
endmodule
